//--- annp_defines.vh
`ifndef ANNP_DEFINES_VH
`define ANNP_DEFINES_VH

// Register offsets on the management bus
`define ANNP_OFS_EXPANSION       5'h06
`define ANNP_OFS_NP_TX           5'h07
`define ANNP_OFS_NP_RX           5'h08

// Expansion status fields
`define ANNP_EXP_PAR_FAULT       4
`define ANNP_EXP_LP_NP_ABLE      3
`define ANNP_EXP_NP_ABLE         2
`define ANNP_EXP_PAGE_RX         1
`define ANNP_EXP_LP_AN_ABLE      0

// Next-page word fields (transmit and received share the layout)
`define ANNP_NP_MORE             15
`define ANNP_NP_RSVD             14
`define ANNP_NP_MSG              13
`define ANNP_NP_ACK2             12
`define ANNP_NP_TOGGLE           11
`define ANNP_NP_CODE_HI          10
`define ANNP_NP_CODE_LO          0

// Reset values
`define ANNP_NP_TX_RST           16'h2001
`define ANNP_NP_RX_RST           16'h0000
`define ANNP_NP_LOCAL_ABLE       1'b1

// Management frame
`define ANNP_PRE_ONES            6'd32
`define ANNP_OP_READ             2'b10
`define ANNP_OP_WRITE            2'b01
`define ANNP_HDR_BITS            4'd12
`define ANNP_DATA_LAST           4'd15

`endif

//--- annp_lh_bit.v
`timescale 1ns/100ps
`include "annp_defines.vh"

module annp_lh_bit (
  input  wire sys_clk_in,
  input  wire rst_n_in,
  input  wire ce_in,
  input  wire set_in,
  input  wire rd_clr_in,
  output wire q_out
);

  reg  q_ff;
  wire nxt_q;

  // Set wins over the read clear, so a condition still present survives the read
  assign nxt_q = set_in | (q_ff & ~rd_clr_in);

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      q_ff <= 1'b0;
    end else if (ce_in) begin
      q_ff <= nxt_q;
    end
  end

  assign q_out = q_ff;

endmodule // annp_lh_bit

//--- annp_regs.v
// Notes on behaviour
// RL1 - Page-received and parallel-fault status bits set on their events and latch high.
// RL2 - Read-only expansion bit shows partner next-page ability; zero after reset.
// RL3 - Read-only expansion bit shows local next-page support; reads one always.
// RL4 - Manager writes more, message and ack2 flags; partner flags readable only.
// RL5 - Toggle bit 11 is read-only in both words, following previous code word.
// RL6 - Transmit code field bits 10..0 writable, reset 001; received field read-only.
// RL7 - Latched-high bits clear after a management read unless condition persists.
`timescale 1ns/100ps
`include "annp_defines.vh"

module annp_regs (
  input  wire        sys_clk_in,
  input  wire        rst_n_in,
  input  wire        ce_in,
  input  wire [4:0]  phy_addr_in,
  input  wire        mdc_in,
  input  wire        mdio_in,
  output wire        mdio_out,
  output wire        mdio_oe_n_out,
  input  wire        page_rx_evt_in,
  input  wire        par_fault_in,
  input  wire        lp_np_able_in,
  input  wire        lp_an_able_in,
  input  wire        lp_np_load_in,
  input  wire [15:0] lp_np_word_in,
  input  wire        np_tx_sent_in,
  output wire [15:0] np_tx_word_out,
  output wire        np_tx_written_out
);

  localparam [2:0] ST_PRE  = 3'd0;
  localparam [2:0] ST_SOF  = 3'd1;
  localparam [2:0] ST_HDR  = 3'd2;
  localparam [2:0] ST_TA   = 3'd3;
  localparam [2:0] ST_DATA = 3'd4;

  // Reset word held at full width so each field takes its own slice of it
  localparam [15:0] TX_RST = `ANNP_NP_TX_RST;

  reg  [2:0]  state_ff;
  reg  [5:0]  ones_ff;
  reg  [3:0]  cnt_ff;
  reg  [11:0] hdr_ff;
  reg  [15:0] shift_ff;
  reg         is_rd_ff;
  reg         is_wr_ff;
  reg         mdc_d_ff;
  reg         mdio_out_ff;
  reg         mdio_oe_n_ff;
  reg         rd_stb_ff;
  reg         wr_stb_ff;
  reg  [4:0]  reg_addr_ff;
  reg  [15:0] wr_data_ff;
  reg  [15:0] rd_data_ff;

  reg         tx_more_ff;
  reg         tx_msg_ff;
  reg         tx_ack2_ff;
  reg         tx_toggle_ff;
  reg  [10:0] tx_code_ff;
  reg  [15:0] rx_word_ff;
  reg         lp_np_able_ff;
  reg         lp_an_able_ff;
  reg         tx_written_ff;

  wire        mdc_rise;
  wire        page_rx_q;
  wire        par_fault_q;
  wire        exp_rd_clr;
  wire [15:0] exp_word;
  wire [15:0] tx_word;
  wire [15:0] rx_word;
  wire [15:0] hdr_next;
  wire        hdr_read;
  wire        hdr_write;
  wire        hdr_mine;

  function [15:0] annp_rd_mux;
    input [4:0]  addr;
    input [15:0] exp_w;
    input [15:0] tx_w;
    input [15:0] rx_w;
    begin
      case (addr)
        `ANNP_OFS_EXPANSION: annp_rd_mux = exp_w;
        `ANNP_OFS_NP_TX:     annp_rd_mux = tx_w;
        `ANNP_OFS_NP_RX:     annp_rd_mux = rx_w;
        default:             annp_rd_mux = 16'h0000;
      endcase
    end
  endfunction

  // MDC is sampled like any synchronous input; only its rising edge matters
  assign mdc_rise = mdc_in & ~mdc_d_ff;
  assign hdr_next = {4'h0, hdr_ff[10:0], mdio_in};
  assign hdr_read  = (hdr_next[11:10] == `ANNP_OP_READ);
  assign hdr_write = (hdr_next[11:10] == `ANNP_OP_WRITE);
  assign hdr_mine  = (hdr_next[9:5] == phy_addr_in);

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_ff     <= ST_PRE;
      ones_ff      <= 6'd0;
      cnt_ff       <= 4'd0;
      hdr_ff       <= 12'h000;
      shift_ff     <= 16'h0000;
      is_rd_ff     <= 1'b0;
      is_wr_ff     <= 1'b0;
      mdc_d_ff     <= 1'b0;
      mdio_out_ff  <= 1'b1;
      mdio_oe_n_ff <= 1'b1;
      rd_stb_ff    <= 1'b0;
      wr_stb_ff    <= 1'b0;
      reg_addr_ff  <= 5'h00;
      wr_data_ff   <= 16'h0000;
    end else if (ce_in) begin
      mdc_d_ff  <= mdc_in;
      rd_stb_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      if (mdc_rise) begin
        case (state_ff)
          ST_PRE: begin
            if (mdio_in) begin
              if (ones_ff != `ANNP_PRE_ONES) begin
                ones_ff <= ones_ff + 6'd1;
              end
            end else if (ones_ff == `ANNP_PRE_ONES) begin
              state_ff <= ST_SOF;
            end else begin
              ones_ff <= 6'd0;
            end
          end
          ST_SOF: begin
            ones_ff <= 6'd0;
            cnt_ff  <= 4'd0;
            state_ff <= mdio_in ? ST_HDR : ST_PRE;
          end
          ST_HDR: begin
            hdr_ff <= hdr_next[11:0];
            cnt_ff <= cnt_ff + 4'd1;
            if (cnt_ff == `ANNP_HDR_BITS - 4'd1) begin
              is_rd_ff    <= hdr_read & hdr_mine;
              is_wr_ff    <= hdr_write & hdr_mine;
              reg_addr_ff <= hdr_next[4:0];
              // Fetch early; a read of the expansion register also clears its latched-high bits
              rd_stb_ff   <= hdr_read & hdr_mine; // RL7
              cnt_ff      <= 4'd0;
              state_ff    <= ST_TA;
            end
          end
          ST_TA: begin
            if (cnt_ff == 4'd0) begin
              cnt_ff <= 4'd1;
              if (is_rd_ff) begin
                mdio_out_ff  <= 1'b0;
                mdio_oe_n_ff <= 1'b0;
                shift_ff     <= rd_data_ff;
              end
            end else begin
              cnt_ff <= 4'd0;
              state_ff <= ST_DATA;
              if (is_rd_ff) begin
                mdio_out_ff <= shift_ff[15];
                shift_ff    <= {shift_ff[14:0], 1'b0};
              end
            end
          end
          ST_DATA: begin
            cnt_ff     <= cnt_ff + 4'd1;
            wr_data_ff <= {wr_data_ff[14:0], mdio_in};
            if (cnt_ff == `ANNP_DATA_LAST) begin
              mdio_oe_n_ff <= 1'b1;
              mdio_out_ff  <= 1'b1;
              wr_stb_ff    <= is_wr_ff;
              ones_ff      <= 6'd0;
              state_ff     <= ST_PRE;
            end else if (is_rd_ff) begin
              mdio_out_ff <= shift_ff[15];
              shift_ff    <= {shift_ff[14:0], 1'b0};
            end
          end
          default: begin
            state_ff <= ST_PRE;
          end
        endcase
      end
    end
  end

  assign exp_rd_clr = rd_stb_ff & (reg_addr_ff == `ANNP_OFS_EXPANSION);

  annp_lh_bit u_page_rx (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .set_in     (page_rx_evt_in), // RL1
    .rd_clr_in  (exp_rd_clr),     // RL7
    .q_out      (page_rx_q)
  );

  annp_lh_bit u_par_fault (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .set_in     (par_fault_in),   // RL1
    .rd_clr_in  (exp_rd_clr),     // RL7
    .q_out      (par_fault_q)
  );

  assign exp_word = {11'h000,
                     par_fault_q,
                     lp_np_able_ff,         // RL2
                     `ANNP_NP_LOCAL_ABLE,   // RL3
                     page_rx_q,
                     lp_an_able_ff};

  // Reserved bit 14 reads zero; toggle is owned by the device, not the manager
  assign tx_word = {tx_more_ff, 1'b0, tx_msg_ff, tx_ack2_ff, tx_toggle_ff, tx_code_ff};
  assign rx_word = {rx_word_ff[15], 1'b0, rx_word_ff[13:0]};

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tx_more_ff    <= TX_RST[`ANNP_NP_MORE];
      tx_msg_ff     <= TX_RST[`ANNP_NP_MSG];
      tx_ack2_ff    <= TX_RST[`ANNP_NP_ACK2];
      tx_toggle_ff  <= TX_RST[`ANNP_NP_TOGGLE];
      tx_code_ff    <= TX_RST[`ANNP_NP_CODE_HI:`ANNP_NP_CODE_LO];
      rx_word_ff    <= `ANNP_NP_RX_RST;
      lp_np_able_ff <= 1'b0;
      lp_an_able_ff <= 1'b0;
      tx_written_ff <= 1'b0;
      rd_data_ff    <= 16'h0000;
    end else if (ce_in) begin
      lp_np_able_ff <= lp_np_able_in; // RL2
      lp_an_able_ff <= lp_an_able_in;
      tx_written_ff <= 1'b0;
      if (rd_stb_ff) begin
        rd_data_ff <= annp_rd_mux(reg_addr_ff, exp_word, tx_word, rx_word);
      end
      if (wr_stb_ff && reg_addr_ff == `ANNP_OFS_NP_TX) begin
        tx_more_ff    <= wr_data_ff[`ANNP_NP_MORE];                    // RL4
        tx_msg_ff     <= wr_data_ff[`ANNP_NP_MSG];                     // RL4
        tx_ack2_ff    <= wr_data_ff[`ANNP_NP_ACK2];                    // RL4
        tx_code_ff    <= wr_data_ff[`ANNP_NP_CODE_HI:`ANNP_NP_CODE_LO]; // RL6
        tx_written_ff <= 1'b1;
      end
      // Each sent page flips the toggle so the next word differs from the last
      if (np_tx_sent_in) begin
        tx_toggle_ff <= ~tx_toggle_ff; // RL5
      end
      // Partner word, toggle and code field come only from the link side
      if (lp_np_load_in) begin
        rx_word_ff <= lp_np_word_in; // RL4 RL5 RL6
      end
    end
  end

  assign mdio_out          = mdio_out_ff;
  assign mdio_oe_n_out     = mdio_oe_n_ff;
  assign np_tx_word_out    = tx_word;
  assign np_tx_written_out = tx_written_ff;

endmodule // annp_regs

//--- annp_regs_monitor.sv
`timescale 1ns/100ps
module annp_regs_monitor (
  input wire        sys_clk_in,
  input wire        rst_n_in,
  input wire        ce_in,
  input wire        np_tx_sent_in,
  input wire        np_tx_written_out,
  input wire [15:0] np_tx_word_out,
  input wire        mdio_oe_n_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_tgl_flip;
    ce_in && np_tx_sent_in |=> np_tx_word_out[11] != $past(np_tx_word_out[11]);
  endproperty
  a_tgl_flip: assert property (p_tgl_flip) else $error("toggle did not flip");
  property p_tgl_hold;
    !(ce_in && np_tx_sent_in) |=> $stable(np_tx_word_out[11]);
  endproperty
  a_tgl_hold: assert property (p_tgl_hold) else $error("toggle moved");
  // Write pulse may trail the word update by a cycle
  property p_flag_wr;
    $changed(np_tx_word_out[15:12]) |-> ##[0:1] np_tx_written_out or $past(np_tx_written_out);
  endproperty
  a_flag_wr: assert property (p_flag_wr) else $error("flags moved without write");
  property p_code_wr;
    $changed(np_tx_word_out[10:0]) |-> ##[0:1] np_tx_written_out or $past(np_tx_written_out);
  endproperty
  a_code_wr: assert property (p_code_wr) else $error("code moved without write");
  property p_rsvd;
    np_tx_word_out[14] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_wr_pulse;
    ce_in && np_tx_written_out |=> !np_tx_written_out;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
  c_wr: cover property (np_tx_written_out);
  c_sent: cover property (np_tx_sent_in);
  c_drive: cover property ($fell(mdio_oe_n_out));
endmodule // annp_regs_monitor

bind annp_regs annp_regs_monitor annp_regs_monitor_inst (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .np_tx_sent_in(np_tx_sent_in), .np_tx_written_out(np_tx_written_out),
  .np_tx_word_out(np_tx_word_out), .mdio_oe_n_out(mdio_oe_n_out));

//--- annp_sta_model.sv
`timescale 1ns/100ps
module annp_sta_model (
  input  wire sys_clk_in,
  input  wire mdio_out,
  input  wire mdio_oe_n_out,
  output reg  sta_mdc_out,
  output wire sta_mdio_out
);
  reg m_oe;
  reg m_bit;
  // Line has a pull-up, so a released wire reads one
  assign sta_mdio_out = !mdio_oe_n_out ? mdio_out : (m_oe ? m_bit : 1'b1);
  initial begin
    sta_mdc_out = 1'b0;
    m_oe = 1'b0;
    m_bit = 1'b1;
  end
  task xfer(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd,
            output [15:0] rd);
    reg [63:0] f;
    integer i;
    begin
      f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
      for (i = 0; i < 64; i = i + 1) begin
        @(negedge sys_clk_in);
        m_oe = (i < 46) || (op == 2'b01);
        m_bit = f[63-i];
        repeat (2) @(negedge sys_clk_in);
        if (i > 47) rd = {rd[14:0], sta_mdio_out};
        sta_mdc_out = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        sta_mdc_out = 1'b0;
      end
      m_oe = 1'b0;
    end
  endtask
endmodule // annp_sta_model

//--- autoneg_expansion_next_page_regs_test.sv
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected %0t: got %h want %h", $time, (a), (e)); end end
module autoneg_expansion_next_page_regs_test;
  reg         sys_clk_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg         ce = 1'b1;
  reg         pg_rx = 1'b0;
  reg         par_flt = 1'b0;
  reg         lp_np = 1'b0;
  reg         lp_an = 1'b0;
  reg         lp_load = 1'b0;
  reg         sent = 1'b0;
  reg  [15:0] lp_word = 16'h0000;
  reg  [15:0] d;
  wire        mdc, mdio, mdio_out, mdio_oe_n, written;
  wire [15:0] tx_word;
  integer     n_errors = 0;
  integer     cmp_count = 0;
  integer     n_wr = 0;
  initial forever #20 sys_clk_in = ~sys_clk_in;
  annp_regs annp_regs_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .phy_addr_in(5'h05), .mdc_in(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
    .mdio_oe_n_out(mdio_oe_n), .page_rx_evt_in(pg_rx), .par_fault_in(par_flt),
    .lp_np_able_in(lp_np), .lp_an_able_in(lp_an), .lp_np_load_in(lp_load),
    .lp_np_word_in(lp_word), .np_tx_sent_in(sent), .np_tx_word_out(tx_word),
    .np_tx_written_out(written));
  annp_sta_model annp_sta_model_inst (.sys_clk_in(sys_clk_in), .mdio_out(mdio_out),
    .mdio_oe_n_out(mdio_oe_n), .sta_mdc_out(mdc), .sta_mdio_out(mdio));
  // Counts write pulses so refused writes can be told from accepted ones
  always @(posedge sys_clk_in) begin
    if (written === 1'b1) n_wr <= n_wr + 1;
  end
  task rd(input [4:0] ra, input [15:0] e);
    begin
      annp_sta_model_inst.xfer(2'b10, 5'h05, ra, 16'h0000, d);
      `CHK(d, e)
    end
  endtask
  task wr(input [4:0] ra, input [15:0] wd);
    begin
      annp_sta_model_inst.xfer(2'b01, 5'h05, ra, wd, d);
    end
  endtask
  task end_sim;
    begin
      if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    @(negedge sys_clk_in);
    `CHK(tx_word, 16'h2001)
    rd(5'h06, 16'h0004);
    rd(5'h07, 16'h2001);
    rd(5'h08, 16'h0000);
    wr(5'h07, 16'hffff);
    repeat (4) @(negedge sys_clk_in);
    `CHK(tx_word, 16'hb7ff)
    rd(5'h07, 16'hb7ff);
    sent = 1'b1;
    @(negedge sys_clk_in) sent = 1'b0;
    rd(5'h07, 16'hbfff);
    wr(5'h07, 16'h0000);
    rd(5'h07, 16'h0800);
    ce = 1'b0;
    sent = 1'b1;
    @(negedge sys_clk_in) sent = 1'b0;
    ce = 1'b1;
    rd(5'h07, 16'h0800);
    rd(5'h09, 16'h0000);
    pg_rx = 1'b1;
    par_flt = 1'b1;
    lp_np = 1'b1;
    lp_an = 1'b1;
    @(negedge sys_clk_in) pg_rx = 1'b0;
    annp_sta_model_inst.xfer(2'b10, 5'h06, 5'h06, 16'h0000, d);
    `CHK(d, 16'hffff)
    rd(5'h06, 16'h001f);
    par_flt = 1'b0;
    rd(5'h06, 16'h001d);
    rd(5'h06, 16'h000d);
    lp_np = 1'b0;
    rd(5'h06, 16'h0005);
    lp_word = 16'hffff;
    lp_load = 1'b1;
    @(negedge sys_clk_in) lp_load = 1'b0;
    rd(5'h08, 16'hbfff);
    wr(5'h08, 16'h0000);
    rd(5'h08, 16'hbfff);
    `CHK(n_wr, 2)
    rst_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    @(negedge sys_clk_in);
    `CHK(tx_word, 16'h2001)
    rd(5'h06, 16'h0005);
    end_sim;
  end
  // About twenty frames of about 400 cycles each, with ample margin
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_errors++;
    end_sim;
  end
endmodule // autoneg_expansion_next_page_regs_test
